// ===== logic/cut_area_code_framer.sv
// Purpose: Builds the burst cut area frame and drives the return-to-zero stripe train.
// Assumes: Byte source sits on clk; start is a one-cycle pulse while idle.
// Notes:   Train never stalls once started; a missing byte is sent as zero and flagged.
`timescale 1ns/1ns
// Contract
// [RULE1] Data-field bit zero becomes channel bits 01, bit one becomes 10.
// [RULE2] Data-field polarity covers information, four check and sixteen parity bytes.
// [RULE3] Outside the data field, bit zero becomes 10 and bit one becomes 01.
// [RULE4] Channel train is return-to-zero: one pulse per channel bit one.
// [RULE5] No pulse lasts longer than half a channel-bit period.
// [RULE6] Preamble, data field and postamble follow back to back without gaps.
// [RULE7] Preamble is one sync byte then four zero bytes.
// [RULE8] Data field: 16n-4 information, four check, sixteen parity bytes, in order.
// [RULE9] Size n is one to twelve; larger requests are refused.
// [RULE10] A resync precedes every group of four data-field bytes.
// [RULE11] Postamble is four 55 bytes with a resync before and after.
// [RULE12] Sync and resync: fixed pattern 01000110, then phase-encoded four-bit index.
// [RULE13] Check bytes are the information remainder modulo x^32+x^31+x^4+1.
// [RULE14] Parity is four-way interleaved Reed-Solomon, four bytes per interleave.
// [RULE15] Resync index 13 before parity rows, 14 before and 15 after postamble.
module cut_area_code_framer
    import cut_area_pkg::*;
#(
    parameter int CHAN_CYC  = CHAN_CYCLES,
    parameter int PULSE_CYC = PULSE_CYCLES
)
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    // Frame control
    input  wire logic       start,
    input  wire logic [3:0] size_n,
    output logic            busy,
    output logic            frame_done,
    output logic            size_err,
    output logic            underrun,
    // Information byte source
    input  wire logic [7:0] in_data,
    input  wire logic       in_valid,
    output logic            in_ready,
    // Stripe train
    output logic            stripe
);

    frame_state_t     state_reg, state_next;
    logic [15:0]      ph_reg, ph_next;
    logic [6:0]       pos_reg, pos_next;
    logic [5:0]       row_reg, row_next;
    logic [3:0]       n_reg, n_next;
    logic [7:0]       cur_reg, cur_next;
    logic [7:0]       hold_reg, hold_next;
    logic             hold_full_reg, hold_full_next;
    logic [7:0]       fetched_reg, fetched_next;
    logic             chbit_reg, chbit_next;
    logic             stripe_reg, stripe_next;
    logic             busy_reg, busy_next;
    logic             done_reg, done_next;
    logic             size_err_reg, size_err_next;
    logic             underrun_reg, underrun_next;
    logic             ready_reg, ready_next;
    logic             eng_clr, eng_feed, eng_info;
    logic [1:0]       eng_lane;
    logic [7:0]       eng_din;
    logic [31:0]      crc_w;
    logic [3:0][31:0] par_w;

    // Check remainder and interleaved parity
    cut_area_parity u_parity (
        .clk     (clk),
        .sys_rst (sys_rst),
        .clr     (eng_clr),
        .feed    (eng_feed),
        .is_info (eng_info),
        .lane    (eng_lane),
        .din     (eng_din),
        .crc     (crc_w),
        .parity  (par_w)
    );

    // Channel bit at a row position for a given code, byte and polarity
    function automatic logic chan_bit(input logic [6:0] pos, input logic [3:0] code,
                                      input logic [7:0] byt, input logic data_pol);
        logic [6:0] q;
        logic [5:0] idx;
        logic       b;
        logic       pol;
        q   = pos - FIX_BITS;
        idx = q[6:1];
        b   = 1'b0;
        pol = 1'b0;
        if (pos < FIX_BITS)
            return FIXED_PAT[3'(7 - pos)];                      // see [RULE12]
        if (idx < 6'd4)
            b = code[2'(3 - idx)];                              // see [RULE12]
        else
        begin
            b   = byt[3'(7 - (idx - 6'd4))];
            pol = data_pol;
        end
        // First half carries the bit in data polarity, its inverse otherwise
        if (pol)
            return q[0] ? ~b : b;                               // see [RULE1] [RULE2]
        return q[0] ? b : ~b;                                   // see [RULE3]
    endfunction

    // Frame sequencing, byte selection and source handshake
    always_comb
    begin
        logic [5:0] n4;
        logic [5:0] rsel;
        logic [1:0] k;
        logic [3:0] code;
        logic       last;
        logic       dpol;
        n4             = {n_reg, 2'b00};
        rsel           = 6'h0;
        k              = 2'b00;
        code           = SYNC_CODE;
        last           = 1'b0;
        dpol           = 1'b0;
        state_next     = state_reg;
        ph_next        = ph_reg;
        pos_next       = pos_reg;
        row_next       = row_reg;
        n_next         = n_reg;
        cur_next       = cur_reg;
        hold_next      = hold_reg;
        hold_full_next = hold_full_reg;
        fetched_next   = fetched_reg;
        chbit_next     = chbit_reg;
        done_next      = 1'b0;
        size_err_next  = size_err_reg;
        underrun_next  = underrun_reg;
        eng_clr        = 1'b0;
        eng_feed       = 1'b0;
        eng_info       = 1'b0;
        eng_lane       = 2'b00;
        eng_din        = 8'h00;
        case (state_reg)
            st_idle:
            begin
                if (start)
                begin
                    if (size_n == 4'h0 || size_n > N_MAX)
                        size_err_next = 1'b1;                   // see [RULE9]
                    else
                    begin
                        state_next     = st_run;
                        n_next         = size_n;
                        ph_next        = 16'h0;
                        pos_next       = 7'h0;
                        row_next       = 6'h0;
                        fetched_next   = 8'h0;
                        hold_full_next = 1'b0;
                        size_err_next  = 1'b0;
                        underrun_next  = 1'b0;
                        eng_clr        = 1'b1;
                        chbit_next     = FIXED_PAT[7];          // see [RULE7]
                    end
                end
            end
            st_run:
            begin
                if (ph_reg == 16'(CHAN_CYC - 1))
                begin
                    ph_next = 16'h0;
                    last = (row_reg == n4 + 6'd6) ? (pos_reg == TAIL_BITS - 7'd1)
                                                  : (pos_reg == ROW_BITS - 7'd1);
                    if (last && row_reg == n4 + 6'd6)
                    begin
                        state_next = st_idle;
                        done_next  = 1'b1;
                        chbit_next = 1'b0;
                    end
                    else
                    begin
                        // Rows follow with no gap between fields
                        pos_next = last ? 7'h0 : pos_reg + 7'd1;     // see [RULE6]
                        row_next = last ? row_reg + 6'd1 : row_reg;
                        dpol = (row_next != 6'h0) && (row_next <= n4 + 6'd4);
                        if (row_next == 6'h0)
                            code = SYNC_CODE;
                        else if (row_next <= n4)
                        begin
                            rsel = row_next - 6'd1;
                            code = 4'(rsel[5:2]) + 4'd1;                // see [RULE10]
                        end
                        else if (row_next <= n4 + 6'd4)
                            code = ECC_CODE;                            // see [RULE15]
                        else if (row_next == n4 + 6'd5)
                            code = POST_CODE;                           // see [RULE11]
                        else
                            code = TAIL_CODE;                           // see [RULE15]
                        // Load the byte that starts at this position
                        if (pos_next >= FIRST_BYTE && pos_next[3:0] == 4'h0)
                        begin
                            k = 2'(pos_next[6:4] - 3'd1);
                            if (row_next == 6'h0)
                                cur_next = PRE_BYTE;                    // see [RULE7]
                            else if (row_next < n4)
                            begin
                                cur_next       = hold_full_reg ? hold_reg : 8'h00;
                                underrun_next  = underrun_reg | ~hold_full_reg;
                                hold_full_next = 1'b0;
                                eng_feed       = 1'b1;                  // see [RULE8]
                                eng_info       = 1'b1;
                                eng_lane       = k;
                                eng_din        = cur_next;
                            end
                            else if (row_next == n4)
                            begin
                                cur_next = crc_w[(3 - k) * 8 +: 8];     // see [RULE13]
                                eng_feed = 1'b1;
                                eng_lane = k;
                                eng_din  = cur_next;
                            end
                            else if (row_next <= n4 + 6'd4)
                            begin
                                rsel     = row_next - n4 - 6'd1;
                                cur_next = par_w[k][(3 - rsel[1:0]) * 8 +: 8]; // see [RULE14]
                            end
                            else
                                cur_next = POST_BYTE;                   // see [RULE11]
                        end
                        chbit_next = chan_bit(pos_next, code, cur_next, dpol);
                    end
                end
                else
                    ph_next = ph_reg + 16'd1;
            end
            default:
                state_next = st_idle;
        endcase
        // Take a byte from the source into the single holding slot
        if (in_valid && ready_reg)
        begin
            hold_next      = in_data;
            hold_full_next = 1'b1;
            fetched_next   = fetched_reg + 8'd1;
        end
        ready_next  = (state_next == st_run) && !hold_full_next
                      && (fetched_next < {n_next, 4'h0} - 8'd4);
        busy_next   = (state_next == st_run);
        // Pulse only in the first half of a one channel bit
        stripe_next = busy_next && chbit_next
                      && (ph_next < 16'(PULSE_CYC));            // see [RULE4] [RULE5]
    end

    // Register the framer state
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_reg     <= st_idle;
            ph_reg        <= 16'h0;
            pos_reg       <= 7'h0;
            row_reg       <= 6'h0;
            n_reg         <= 4'h1;
            cur_reg       <= 8'h00;
            hold_reg      <= 8'h00;
            hold_full_reg <= 1'b0;
            fetched_reg   <= 8'h00;
            chbit_reg     <= 1'b0;
            stripe_reg    <= 1'b0;
            busy_reg      <= 1'b0;
            done_reg      <= 1'b0;
            size_err_reg  <= 1'b0;
            underrun_reg  <= 1'b0;
            ready_reg     <= 1'b0;
        end
        else
        begin
            state_reg     <= state_next;
            ph_reg        <= ph_next;
            pos_reg       <= pos_next;
            row_reg       <= row_next;
            n_reg         <= n_next;
            cur_reg       <= cur_next;
            hold_reg      <= hold_next;
            hold_full_reg <= hold_full_next;
            fetched_reg   <= fetched_next;
            chbit_reg     <= chbit_next;
            stripe_reg    <= stripe_next;
            busy_reg      <= busy_next;
            done_reg      <= done_next;
            size_err_reg  <= size_err_next;
            underrun_reg  <= underrun_next;
            ready_reg     <= ready_next;
        end
    end

    // Outputs straight from flops
    assign stripe     = stripe_reg;
    assign busy       = busy_reg;
    assign frame_done = done_reg;
    assign size_err   = size_err_reg;
    assign underrun   = underrun_reg;
    assign in_ready   = ready_reg;

endmodule

// ===== logic/cut_area_pkg.sv
// Purpose: Shared constants and types for the burst cut area framer.
// Assumes: 20 MHz system clock; one channel bit spans a whole number of clocks.
// Notes:   Row = resync (8 fixed channel bits + 4 code bits) + 4 phase-encoded bytes.
package cut_area_pkg;

    // Clock and channel-bit timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int CHAN_BIT_NS   = 4445;
    localparam int CHAN_CYCLES   = (CHAN_BIT_NS / CLK_PERIOD_NS < 2) ? 2
                                   : CHAN_BIT_NS / CLK_PERIOD_NS;
    localparam int PULSE_CYCLES  = CHAN_CYCLES / 2;

    // Frame constants
    localparam logic [7:0] FIXED_PAT  = 8'h46;
    localparam logic [7:0] PRE_BYTE   = 8'h00;
    localparam logic [7:0] POST_BYTE  = 8'h55;
    localparam logic [3:0] SYNC_CODE  = 4'h0;
    localparam logic [3:0] ECC_CODE   = 4'hd;
    localparam logic [3:0] POST_CODE  = 4'he;
    localparam logic [3:0] TAIL_CODE  = 4'hf;
    localparam logic [3:0] N_MAX      = 4'hc;
    localparam logic [6:0] FIX_BITS   = 7'h08;
    localparam logic [6:0] FIRST_BYTE = 7'h10;
    localparam logic [6:0] ROW_BITS   = 7'h50;
    localparam logic [6:0] TAIL_BITS  = 7'h10;

    // Check and parity polynomials
    localparam logic [31:0] CRC_POLY = 32'h80000011;
    localparam logic [7:0]  GF_POLY  = 8'h1d;
    localparam logic [7:0]  RS_G3    = 8'h0f;
    localparam logic [7:0]  RS_G2    = 8'h36;
    localparam logic [7:0]  RS_G1    = 8'h78;
    localparam logic [7:0]  RS_G0    = 8'h40;

    typedef enum logic {st_idle, st_run} frame_state_t;

endpackage

// ===== logic/cut_area_parity.sv
// Purpose: Detection check remainder and four-way interleaved parity engine.
// Assumes: Bytes are fed most significant bit first, one per feed pulse.
// Notes:   Lane j holds its parity as {C(j,0), C(j,1), C(j,2), C(j,3)}.
`timescale 1ns/1ns
module cut_area_parity
    import cut_area_pkg::*;
(
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          sys_rst,
    // Byte feed
    input  wire logic          clr,
    input  wire logic          feed,
    input  wire logic          is_info,
    input  wire logic [1:0]    lane,
    input  wire logic [7:0]    din,
    // Results
    output logic      [31:0]   crc,
    output logic      [3:0][31:0] parity
);

    logic [31:0]       crc_reg;
    logic [31:0]       crc_next;
    logic [3:0][31:0]  par_reg;
    logic [3:0][31:0]  par_next;

    // Multiply in the byte field
    function automatic logic [7:0] gf_mul(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] p;
        logic [7:0] x;
        p = 8'h00;
        x = a;
        for (int i = 0; i < 8; i++)
        begin
            if (b[i])
                p = p ^ x;
            x = x[7] ? ((x << 1) ^ GF_POLY) : (x << 1);
        end
        return p;
    endfunction

    // Shift one byte through the 32-bit remainder, high bit first
    function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] r;
        r = c;
        for (int i = 7; i >= 0; i--)
            r = (d[i] ^ r[31]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
        return r;
    endfunction

    // Next remainder and parity for the fed byte
    always_comb
    begin
        logic [7:0]  fb;
        logic [31:0] l;
        fb       = 8'h00;
        l        = 32'h0;
        crc_next = crc_reg;
        par_next = par_reg;
        if (clr)
        begin
            crc_next = 32'h0;
            par_next = '0;
        end
        else if (feed)
        begin
            if (is_info)
                crc_next = crc_step(crc_reg, din);              // see [RULE13]
            l  = par_reg[lane];
            fb = din ^ l[31:24];
            par_next[lane] = {l[23:16] ^ gf_mul(fb, RS_G3),     // see [RULE14]
                              l[15:8] ^ gf_mul(fb, RS_G2),
                              l[7:0] ^ gf_mul(fb, RS_G1),
                              gf_mul(fb, RS_G0)};
        end
    end

    // Register the engine state
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            crc_reg <= 32'h0;
            par_reg <= '0;
        end
        else
        begin
            crc_reg <= crc_next;
            par_reg <= par_next;
        end
    end

    assign crc    = crc_reg;
    assign parity = par_reg;

endmodule

// ===== tb/cut_area_code_framer_checker.sv
// Purpose: Port-level timing checks for the framer.
// Assumes: Parameters match the bound instance.
// Notes:   Helper counters track pulse width, bit phase and frame length.
`timescale 1ns/1ns
module cut_area_code_framer_checker
    import cut_area_pkg::*;
#(
    parameter int CHAN_CYC  = 4,
    parameter int PULSE_CYC = 2
)
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    // Observed ports
    input  wire logic       start,
    input  wire logic [3:0] size_n,
    input  wire logic       busy,
    input  wire logic       frame_done,
    input  wire logic       size_err,
    input  wire logic       in_valid,
    input  wire logic       in_ready,
    input  wire logic       stripe
);
    int         hi_reg, hi_next, ph_reg, ph_next, len_reg, len_next;
    logic [3:0] n_reg, n_next;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Pulse width, bit phase, busy length and latched size
    always_comb
    begin
        hi_next  = stripe ? hi_reg + 1 : 0;
        ph_next  = (!busy || ph_reg == CHAN_CYC - 1) ? 0 : ph_reg + 1;
        len_next = busy ? len_reg + 1 : 0;
        n_next   = (start && !busy) ? size_n : n_reg;
    end
    // Register the helper counters
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            hi_reg  <= 0;
            ph_reg  <= 0;
            len_reg <= 0;
            n_reg   <= 4'h0;
        end
        else
        begin
            hi_reg  <= hi_next;
            ph_reg  <= ph_next;
            len_reg <= len_next;
            n_reg   <= n_next;
        end
    end
    a_pulse_half: assert property (stripe |-> hi_reg < PULSE_CYC)
        else $error("stripe pulse too long");
    a_pulse_phase: assert property (stripe |-> ph_reg < PULSE_CYC)
        else $error("stripe pulse off the bit start");
    a_idle_dark: assert property (!busy |-> !stripe)
        else $error("stripe while idle");
    a_start_taken: assert property (start && !busy && size_n != 4'h0
        && size_n <= N_MAX |=> busy && !size_err) else $error("legal start not taken");
    a_size_refused: assert property (start && !busy
        && (size_n == 4'h0 || size_n > N_MAX) |=> size_err && !busy)
        else $error("illegal size not refused");
    a_done_pulse: assert property (frame_done |->
        (!busy && $past(busy)) ##1 !frame_done)
        else $error("frame done not a single pulse at frame end");
    a_end_done: assert property ($fell(busy) |-> frame_done)
        else $error("busy fell without frame done");
    a_frame_len: assert property ($fell(busy) |->
        len_reg == (80 * (4 * int'(n_reg) + 6) + 16) * CHAN_CYC)
        else $error("frame length wrong");
    a_slot_single: assert property (in_valid && in_ready |=> !in_ready)
        else $error("ready stayed after a take");
    a_ready_idle: assert property (!busy |-> !in_ready)
        else $error("ready while idle");
    a_first_bits: assert property ($rose(busy) |-> !stripe ##CHAN_CYC stripe)
        else $error("fixed pattern start wrong");
endmodule

// ===== tb/byte_source.sv
// Purpose: Upstream byte supplier for the framer.
// Assumes: Handshake sampled on the rising edge.
// Notes:   Released data shows a toggling pattern; slow mode idles between bytes.
`timescale 1ns/1ns
module byte_source
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    // Test control
    input  wire logic       en,
    input  wire logic       slow,
    input  wire logic       clr,
    // Byte handshake
    input  wire logic       in_ready,
    output logic      [7:0] in_data,
    output logic            in_valid
);
    int   idx;
    int   gap;
    logic took;
    // Values before the first reset edge
    initial
    begin
        in_valid = 1'b0;
        in_data  = 8'h00;
    end
    // See the take at the same edge as the framer
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            took <= 1'b0;
        else
            took <= in_valid && in_ready;
    end
    // Offer bytes in order, release after each take
    always @(negedge clk or posedge sys_rst)
    begin
        if (sys_rst || clr)
        begin
            idx = 0;
            gap = 0;
            in_valid <= 1'b0;
        end
        else if (took)
        begin
            idx = idx + 1;
            gap = slow ? 30 : 0;
            in_valid <= 1'b0;
            in_data  <= ~in_data;
        end
        else if (gap == 0 && en)
        begin
            in_valid <= 1'b1;
            in_data  <= 8'(idx * 37 + 90);
        end
        else
        begin
            gap = (gap > 0) ? gap - 1 : 0;
            in_data <= ~in_data;
        end
    end
endmodule

// ===== tb/tb_cut_area_code_framer.sv
// Purpose: Self-checking bench decoding the stripe train bit by bit.
// Assumes: Short channel bit of 4 clocks, pulse of 2.
// Notes:   Parity bytes come from a lane-by-lane model of the interleaved code.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end
module tb_cut_area_code_framer;
    import cut_area_pkg::*;
    localparam int CC = 4;
    localparam int PC = 2;
    typedef struct {logic [3:0] n; bit slow; bit starve; bit poke; logic under;} row_t;
    row_t rows [4] = '{'{4'h1, 0, 0, 1, 1'b0}, '{4'hc, 1, 0, 0, 1'b0},
                       '{4'h2, 0, 1, 0, 1'b1}, '{4'h3, 0, 0, 0, 1'b0}};
    logic       clk = 1'b0;
    logic       sys_rst = 1'b1;
    logic       start = 1'b0;
    logic [3:0] size_n = 4'h0;
    logic       src_en = 1'b0;
    logic       src_slow = 1'b0;
    logic       src_clr = 1'b0;
    logic       busy, frame_done, size_err, underrun, in_valid, in_ready, stripe;
    logic [7:0] in_data;
    int         miscompares = 0;
    int         n_tests = 0;
    int         cycles = 0;
    logic       exp_q [$];
    logic       smp [$];

    // Clock at 20 MHz
    always #25 clk = ~clk;

    cut_area_code_framer #(.CHAN_CYC(CC), .PULSE_CYC(PC)) DUT (.clk(clk), .sys_rst(sys_rst),
        .start(start), .size_n(size_n), .busy(busy), .frame_done(frame_done),
        .size_err(size_err), .underrun(underrun), .in_data(in_data), .in_valid(in_valid),
        .in_ready(in_ready), .stripe(stripe));
    byte_source src (.clk(clk), .sys_rst(sys_rst), .en(src_en), .slow(src_slow),
        .clr(src_clr), .in_ready(in_ready), .in_data(in_data), .in_valid(in_valid));

    // Cut a hang short
    always @(posedge clk)
    begin
        cycles++;
        if (cycles > 60000)
        begin
            miscompares++;
            final_report();
        end
    end

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Phase-encode w bits; dat selects data-field polarity, dc marks unknown
    task automatic put(input logic [7:0] v, input int w, input bit dat, input bit dc);
        for (int i = w - 1; i >= 0; i--)
        begin
            exp_q.push_back(dc ? 1'bx : (dat ? v[i] : ~v[i]));
            exp_q.push_back(dc ? 1'bx : (dat ? ~v[i] : v[i]));
        end
    endtask

    task automatic hdr(input logic [3:0] code);
        for (int i = 7; i >= 0; i--)
            exp_q.push_back(FIXED_PAT[i]);
        put({4'h0, code}, 4, 1'b0, 1'b0);
    endtask

    // Field product, high bit of b first
    function automatic logic [7:0] gm(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] p;
        p = 8'h00;
        for (int i = 7; i >= 0; i--)
            p = {p[6:0], 1'b0} ^ (p[7] ? GF_POLY : 8'h00) ^ (b[i] ? a : 8'h00);
        return p;
    endfunction

    // Expected channel bits of a whole frame
    task automatic build(input row_t r);
        logic [7:0]       b;
        logic [7:0]       pf;
        logic [31:0]      crc;
        logic [3:0][31:0] par;
        logic             fb;
        int               ni;
        exp_q.delete();
        crc = 32'h0;
        par = '0;
        ni = 16 * r.n - 4;
        hdr(4'h0);
        repeat (4) put(8'h00, 8, 1'b0, 1'b0);
        for (int k = 0; k < 16 * r.n; k++)
        begin
            if (k % 4 == 0)
                hdr(4'(k / 16 + 1));
            b = (k < ni) ? (r.starve ? 8'h00 : 8'(k * 37 + 90)) : crc[31 - 8 * (k - ni) -: 8];
            for (int i = 7; i >= 0 && k < ni; i--)
            begin
                fb = crc[31] ^ b[i];
                crc = {crc[30:0], 1'b0} ^ (fb ? 32'h80000011 : 32'h0);
            end
            // Each interleave divides its own bytes by the four-root generator
            pf = b ^ par[k % 4][31:24];
            par[k % 4] = {par[k % 4][23:0], 8'h00} ^ {gm(pf, RS_G3), gm(pf, RS_G2),
                gm(pf, RS_G1), gm(pf, RS_G0)};
            put(b, 8, 1'b1, 1'b0);
        end
        for (int i = 0; i < 4; i++)
        begin
            hdr(4'hd);
            for (int j = 0; j < 4; j++)
                put(par[j][31 - 8 * i -: 8], 8, 1'b1, 1'b0);
        end
        hdr(4'he);
        repeat (4) put(8'h55, 8, 1'b0, 1'b0);
        hdr(4'hf);
    endtask

    task automatic run_frame(input row_t r);
        int   bad;
        int   shp;
        logic g;
        build(r);
        smp.delete();
        bad = 0;
        shp = 0;
        @(negedge clk);
        src_clr <= 1'b1;
        src_en <= !r.starve;
        src_slow <= r.slow;
        @(negedge clk);
        src_clr <= 1'b0;
        start = 1'b1;
        size_n = r.n;
        @(negedge clk);
        start = 1'b0;
        size_n = 4'hc;
        while (busy === 1'b1)
        begin
            smp.push_back(stripe);
            start = r.poke && smp.size() == 600;
            @(negedge clk);
        end
        `CHK("frame_done", 1'b1, frame_done)
        for (int k = 0; k < exp_q.size() && (k + 1) * CC <= smp.size(); k++)
        begin
            g = smp[k * CC];
            if (exp_q[k] === 1'bx)
                bad += (k % 2 == 0 && g === smp[(k + 1) * CC]) ? 1 : 0;
            else
                bad += (g !== exp_q[k]) ? 1 : 0;
            for (int j = 0; j < CC; j++)
                shp += (smp[k * CC + j] !== (j < PC ? g : 1'b0)) ? 1 : 0;
        end
        `CHK("length", exp_q.size() * CC, smp.size())
        `CHK("bits", 0, bad)
        `CHK("shape", 0, shp)
        `CHK("underrun", r.under, underrun)
        `CHK("size_err", 1'b0, size_err)
        $display("frame test n=%0d done", r.n);
    endtask

    // Main sequence: reset, refused sizes, frame table, reset in mid-run
    initial
    begin
        repeat (10) @(negedge clk);
        sys_rst = 1'b0;
        `CHK("busy", 1'b0, busy)
        `CHK("stripe", 1'b0, stripe)
        $display("reset test done");
        for (int i = 0; i < 2; i++)
        begin
            @(negedge clk);
            start = 1'b1;
            size_n = i ? 4'hd : 4'h0;
            @(negedge clk);
            start = 1'b0;
            `CHK("size_err", 1'b1, size_err)
            `CHK("busy", 1'b0, busy)
        end
        $display("size refusal test done");
        foreach (rows[i])
            run_frame(rows[i]);
        start = 1'b1;
        size_n = 4'h1;
        @(negedge clk);
        start = 1'b0;
        repeat (100) @(negedge clk);
        sys_rst = 1'b1;
        @(negedge clk);
        `CHK("busy", 1'b0, busy)
        `CHK("in_ready", 1'b0, in_ready)
        sys_rst = 1'b0;
        repeat (2) @(negedge clk);
        $display("mid-run reset test done");
        final_report();
    end
endmodule

bind cut_area_code_framer cut_area_code_framer_checker #(.CHAN_CYC(CHAN_CYC),
    .PULSE_CYC(PULSE_CYC)) chk (.clk(clk), .sys_rst(sys_rst), .start(start),
    .size_n(size_n), .busy(busy), .frame_done(frame_done), .size_err(size_err),
    .in_valid(in_valid), .in_ready(in_ready), .stripe(stripe));
